// ===== rtl/ldr_pkg.sv
// Constants shared by the distributed look-up-table RAM cell and its register slave.
package ldr_pkg;

  localparam int          LDR_LUT_ADDR_W  = 4;
  localparam int          LDR_LUT_WORDS   = 16;
  localparam int          LDR_APB_ADDR_W  = 8;
  localparam int          LDR_DATA_W      = 32;

  localparam logic [7:0]  LDR_OFF_CTRL    = 8'h00;
  localparam logic [7:0]  LDR_OFF_FUNC_A  = 8'h04;
  localparam logic [7:0]  LDR_OFF_FUNC_B  = 8'h08;
  localparam logic [7:0]  LDR_OFF_STATUS  = 8'h0C;

  localparam int          LDR_CTRL_W      = 16;
  localparam int          LDR_MODE_LSB    = 0;
  localparam int          LDR_MODE_W      = 2;
  localparam int          LDR_ASYNC_BIT   = 2;
  localparam int          LDR_A_EN_BIT    = 3;
  localparam int          LDR_B_EN_BIT    = 4;
  localparam int          LDR_H_LSB       = 8;
  localparam int          LDR_H_W         = 8;
  localparam logic [15:0] LDR_CTRL_MASK   = 16'hFF1F;
  localparam logic [15:0] LDR_CTRL_RESET  = 16'h0018;

  localparam int          LDR_ST_A_OUT    = 0;
  localparam int          LDR_ST_B_OUT    = 1;
  localparam int          LDR_ST_A_REG    = 2;
  localparam int          LDR_ST_B_REG    = 3;
  localparam int          LDR_ST_H_REG    = 4;

  // Memory arrangement of the two generators.
  localparam logic [1:0]  LDR_MODE_PAIR   = 2'h0;
  localparam logic [1:0]  LDR_MODE_WIDE   = 2'h1;
  localparam logic [1:0]  LDR_MODE_DUAL   = 2'h2;

endpackage : ldr_pkg

// ===== rtl/ldr_lut16.sv
// One look-up-table function generator usable as logic or as a small RAM.
`timescale 1ns/1ps
`default_nettype none
module ldr_lut16
  import ldr_pkg::*;
#(
  parameter int ADDR_W = LDR_LUT_ADDR_W
) (
  input  wire logic                     clk,
  input  wire logic                     wrEn,
  input  wire logic [ADDR_W-1:0]        wrAddr,
  input  wire logic                     wrData,
  input  wire logic                     transparent,
  input  wire logic                     loadEn,
  input  wire logic [(1<<ADDR_W)-1:0]   loadValue,
  input  wire logic [ADDR_W-1:0]        rdAddr,
  output logic                          rdData,
  output logic      [(1<<ADDR_W)-1:0]   contents
);

  localparam int WORDS = 1 << ADDR_W;

  if (ADDR_W < 1 || ADDR_W > 5) begin : gBadWidth
    $error("ldr_lut16: ADDR_W must lie between 1 and 5");
  end

  // Contents are user data and carry no reset, as in a configured array.
  logic [WORDS-1:0] cells_reg;

  for (genvar i = 0; i < WORDS; i++) begin : gCell
    always_ff @(posedge clk) begin
      if (loadEn) begin
        cells_reg[i] <= loadValue[i];
      end else if (wrEn && wrAddr == ADDR_W'(i)) begin
        cells_reg[i] <= wrData;
      end
    end
  end

  // The four address inputs pick one cell; the read needs no clock.
  always_comb begin
    if (transparent && wrEn && wrAddr == rdAddr) begin
      rdData = wrData;
    end else begin
      rdData = cells_reg[rdAddr];
    end
  end

  assign contents = cells_reg;

endmodule : ldr_lut16
`default_nettype wire

// ===== rtl/ldr_top.sv
// Logic cell with two function generators configurable as distributed RAM, set up over APB.
//
// Functional notes
// - two independent 16x1 memories, own data.
// - generators combine into one 32x1 memory.
// - non-RAM generator keeps working as logic.
// - synchronous write on clock edge, enable gated.
// - asynchronous write follows the write strobe level.
// - timing mode shared by both generators.
// - single port shares read and write address.
// - dual port: one write, two reads.
// - same-cycle read and write in dual port.
// - reads identical in every mode.
// - reads are combinational, no clock needed.
// - four generator inputs address the table.
// - control lines become data and write enable.
// - upper data bit is fifth address bit.
// - outputs leave directly or via flip-flops.
// - flip-flops behave unchanged with RAM use.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ldr_top
  import ldr_pkg::*;
#(
  parameter int APB_ADDR_W = LDR_APB_ADDR_W
) (
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [APB_ADDR_W-1:0]   paddr,
  input  wire logic [LDR_DATA_W-1:0]   pwdata,
  output logic      [LDR_DATA_W-1:0]   prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [LDR_LUT_ADDR_W-1:0] lutAAddress,
  input  wire logic [LDR_LUT_ADDR_W-1:0] lutBAddress,
  input  wire logic                    directInputLine,
  input  wire logic                    auxInputLine,
  input  wire logic                    setResetLine,
  output logic                         lutAOut,
  output logic                         lutBOut,
  output logic                         lutAReg,
  output logic                         lutBReg,
  output logic                         lutHReg
);

  // The upper-bit check below needs at least one bit above the register offsets.
  if (APB_ADDR_W < 5 || APB_ADDR_W > 32) begin : gBadAddr
    $error("ldr_top: APB_ADDR_W must lie between 5 and 32");
  end

  logic                        rstMeta_reg;
  logic                        rstSyncB_reg;
  logic [LDR_CTRL_W-1:0]       ctrl_reg;
  logic                        pready_reg;
  logic                        pslverr_reg;
  logic [LDR_DATA_W-1:0]       prdata_reg;
  logic                        lutAReg_reg;
  logic                        lutBReg_reg;
  logic                        lutHReg_reg;
  logic [1:0]                  ramMode;
  logic                        asyncTiming;
  logic                        effAsync;
  logic                        ramAEn;
  logic                        ramBEn;
  logic [LDR_H_W-1:0]          hTable;
  logic                        ramDataInLow;
  logic                        ramDataInHigh;
  logic                        ramWriteEnable;
  logic                        bothGens;
  logic                        weA;
  logic                        weB;
  logic [LDR_LUT_ADDR_W-1:0]   wrAddrB;
  logic                        wrDataB;
  logic [LDR_LUT_ADDR_W-1:0]   rdAddrB;
  logic                        aRd;
  logic                        bRd;
  logic [LDR_LUT_WORDS-1:0]    aContents;
  logic [LDR_LUT_WORDS-1:0]    bContents;
  logic                        apbSetupPhase;
  logic                        apbWrite;
  logic                        addrHit;
  logic                        loadA;
  logic                        loadB;
  logic [7:0]                  regAddr;
  logic [LDR_DATA_W-1:0]       readMux;
  logic [2:0]                  hIndex;

  // Reset is released through two flip-flops so that its removal is synchronous.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_reg  <= 1'b0;
      rstSyncB_reg <= 1'b0;
    end else begin
      rstMeta_reg  <= 1'b1;
      rstSyncB_reg <= rstMeta_reg;
    end
  end

  default clocking cbMain @(posedge clk);
  endclocking
  default disable iff (!rstSyncB_reg);

  // ---------------------------------------------------------------- APB slave
  assign regAddr       = 8'(paddr);
  assign apbSetupPhase = psel && !penable;
  assign apbWrite      = psel && penable && pwrite && pready_reg;
  assign addrHit       = (APB_ADDR_W == 8 || paddr[APB_ADDR_W-1:4] == '0) &&
                         (regAddr == LDR_OFF_CTRL || regAddr == LDR_OFF_FUNC_A ||
                          regAddr == LDR_OFF_FUNC_B || regAddr == LDR_OFF_STATUS);
  assign loadA         = apbWrite && addrHit && regAddr == LDR_OFF_FUNC_A;
  assign loadB         = apbWrite && addrHit && regAddr == LDR_OFF_FUNC_B;

  always_comb begin
    readMux = '0;
    if (addrHit) begin
      case (regAddr)
        LDR_OFF_CTRL:   readMux = LDR_DATA_W'(ctrl_reg);
        LDR_OFF_FUNC_A: readMux = LDR_DATA_W'(aContents);
        LDR_OFF_FUNC_B: readMux = LDR_DATA_W'(bContents);
        LDR_OFF_STATUS: readMux = LDR_DATA_W'({lutHReg_reg, lutBReg_reg, lutAReg_reg, lutBOut, lutAOut});
        default:        readMux = '0;
      endcase
    end
  end

  // Answer is prepared in the setup phase so that every access completes in one access cycle.
  always_ff @(posedge clk or negedge rstSyncB_reg) begin
    if (!rstSyncB_reg) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else begin
      pready_reg  <= apbSetupPhase;
      pslverr_reg <= apbSetupPhase && !addrHit;
      prdata_reg  <= (apbSetupPhase && !pwrite) ? readMux : '0;
    end
  end

  always_ff @(posedge clk or negedge rstSyncB_reg) begin
    if (!rstSyncB_reg) begin
      ctrl_reg <= LDR_CTRL_RESET;
    end else if (apbWrite && addrHit && regAddr == LDR_OFF_CTRL) begin
      ctrl_reg <= pwdata[LDR_CTRL_W-1:0] & LDR_CTRL_MASK;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  sequence apbSetup;
    psel && !penable;
  endsequence

  apbAnswer_a: assert property (apbSetup |=> pready && (pslverr == !$past(addrHit)))
    else $error("APB access not answered in the first access cycle");

  // ---------------------------------------------------------- configuration
  assign ramMode     = ctrl_reg[LDR_MODE_LSB +: LDR_MODE_W];
  assign asyncTiming = ctrl_reg[LDR_ASYNC_BIT];
  assign ramAEn      = ctrl_reg[LDR_A_EN_BIT];
  assign ramBEn      = ctrl_reg[LDR_B_EN_BIT];
  assign hTable      = ctrl_reg[LDR_H_LSB +: LDR_H_W];
  // The dual-port arrangement exists only with edge-triggered timing.
  assign effAsync    = asyncTiming && ramMode != LDR_MODE_DUAL;
  assign bothGens    = ramMode == LDR_MODE_WIDE || ramMode == LDR_MODE_DUAL;

  // --------------------------------------------------------- write routing
  assign ramDataInLow   = directInputLine;
  assign ramDataInHigh  = auxInputLine;
  assign ramWriteEnable = setResetLine;

  always_comb begin
    weA     = 1'b0;
    weB     = 1'b0;
    wrAddrB = lutBAddress;
    wrDataB = ramDataInHigh;
    rdAddrB = lutBAddress;
    case (ramMode)
      LDR_MODE_WIDE: begin
        weA     = ramWriteEnable && !ramDataInHigh;
        weB     = ramWriteEnable && ramDataInHigh;
        wrAddrB = lutAAddress;
        wrDataB = ramDataInLow;
        rdAddrB = lutAAddress;
      end
      LDR_MODE_DUAL: begin
        weA     = ramWriteEnable;
        weB     = ramWriteEnable;
        wrAddrB = lutAAddress;
        wrDataB = ramDataInLow;
        rdAddrB = lutBAddress;
      end
      default: begin
        // A generator left out of RAM use keeps its table and acts as logic.
        weA     = ramWriteEnable && (ramAEn || bothGens);
        weB     = ramWriteEnable && (ramBEn || bothGens);
        wrAddrB = lutBAddress;
        wrDataB = ramDataInHigh;
        rdAddrB = lutBAddress;
      end
    endcase
  end

  ldr_lut16 #(
    .ADDR_W      (LDR_LUT_ADDR_W)
  ) uLutA (
    .clk         (clk),
    .wrEn        (weA),
    .wrAddr      (lutAAddress),
    .wrData      (ramDataInLow),
    .transparent (effAsync),
    .loadEn      (loadA),
    .loadValue   (pwdata[LDR_LUT_WORDS-1:0]),
    .rdAddr      (lutAAddress),
    .rdData      (aRd),
    .contents    (aContents)
  );

  ldr_lut16 #(
    .ADDR_W      (LDR_LUT_ADDR_W)
  ) uLutB (
    .clk         (clk),
    .wrEn        (weB),
    .wrAddr      (wrAddrB),
    .wrData      (wrDataB),
    .transparent (effAsync),
    .loadEn      (loadB),
    .loadValue   (pwdata[LDR_LUT_WORDS-1:0]),
    .rdAddr      (rdAddrB),
    .rdData      (bRd),
    .contents    (bContents)
  );

  syncWriteA_a: assert property ((ramMode == LDR_MODE_PAIR && !effAsync && weA && !loadA) |=>
                                 aContents[$past(lutAAddress)] == $past(directInputLine))
    else $error("Synchronous write to generator A not stored at the edge");

  weGate_a: assert property ((!setResetLine && !loadA && !loadB) |=>
                             $stable(aContents) && $stable(bContents))
    else $error("Memory changed without write enable");

  asyncTransp_a: assert property ((effAsync && weA && !loadA) |-> lutAOut == directInputLine)
    else $error("Level-sensitive write not visible while the strobe is high");

  sameTiming_a: assert property ((effAsync && weB && !loadB) |-> bRd == wrDataB)
    else $error("Generator B does not follow the shared level-sensitive timing");

  combRead_a: assert property (!(effAsync && weA) |-> aRd == aContents[lutAAddress])
    else $error("Generator A read does not show the addressed cell");

  wideWrite_a: assert property ((ramMode == LDR_MODE_WIDE && !effAsync && setResetLine && auxInputLine
                                 && !loadA && !loadB) |=>
                                bContents[$past(lutAAddress)] == $past(directInputLine) && $stable(aContents))
    else $error("Upper half of the 32-word memory not written as addressed");

  dualMirror_a: assert property ((ramMode == LDR_MODE_DUAL && setResetLine && !loadA && !loadB) |=>
                                 aContents[$past(lutAAddress)] == $past(directInputLine) &&
                                 bContents[$past(lutAAddress)] == $past(directInputLine))
    else $error("Dual-port write not mirrored into both generators");

  dualRead_a: assert property (ramMode == LDR_MODE_DUAL |-> lutBOut == bContents[lutBAddress] &&
                               lutAOut == aContents[lutAAddress])
    else $error("Dual-port read ports not independent");

  // ------------------------------------------------------------- read side
  // Reads bypass the flip-flops on purpose: the direct outputs are combinational in every mode.
  always_comb begin
    if (ramMode == LDR_MODE_WIDE && ramDataInHigh) begin
      lutAOut = bRd;
    end else begin
      lutAOut = aRd;
    end
  end

  assign lutBOut = bRd;
  assign hIndex  = {auxInputLine, bRd, lutAOut};

  // The cell flip-flops sample the generator outputs exactly as they would sample logic.
  always_ff @(posedge clk or negedge rstSyncB_reg) begin
    if (!rstSyncB_reg) begin
      lutAReg_reg <= 1'b0;
      lutBReg_reg <= 1'b0;
      lutHReg_reg <= 1'b0;
    end else begin
      lutAReg_reg <= lutAOut;
      lutBReg_reg <= lutBOut;
      lutHReg_reg <= hTable[hIndex];
    end
  end

  assign lutAReg = lutAReg_reg;
  assign lutBReg = lutBReg_reg;
  assign lutHReg = lutHReg_reg;

  regOut_a: assert property ((rstSyncB_reg && $past(rstSyncB_reg)) |->
                             lutAReg == $past(lutAOut) && lutBReg == $past(lutBOut))
    else $error("Cell flip-flops do not capture the generator outputs");

  logicKeep_a: assert property ((ramMode == LDR_MODE_PAIR && !ramAEn && !loadA) |=> $stable(aContents))
    else $error("Generator A used as logic was overwritten");

endmodule : ldr_top
`default_nettype wire

// ===== verification/ldr_user_logic.sv
// Model of the user logic that drives the cell's RAM port from the array.
`timescale 1ns/1ps
`default_nettype none
module ldr_user_logic
  import ldr_pkg::*;
(
  input  wire logic                      clk,
  output logic      [LDR_LUT_ADDR_W-1:0] lutAAddress,
  output logic      [LDR_LUT_ADDR_W-1:0] lutBAddress,
  output logic                           directInputLine,
  output logic                           auxInputLine,
  output logic                           setResetLine
);
  initial begin
    lutAAddress     = 4'h0;
    lutBAddress     = 4'h0;
    directInputLine = 1'b0;
    auxInputLine    = 1'b0;
    setResetLine    = 1'b0;
  end

  // Everything changes just after a rising edge and stands a whole cycle, so the sampling edge never sees a change.
  task automatic drive(input logic [3:0] a, input logic [3:0] b, input logic d, input logic x, input logic we);
    @(posedge clk);
    lutAAddress     <= a;
    lutBAddress     <= b;
    directInputLine <= d;
    auxInputLine    <= x;
    setResetLine    <= we;
  endtask : drive
endmodule : ldr_user_logic
`default_nettype wire

// ===== verification/ldr_top_bench.sv
// Self-checking bench for the distributed RAM cell and its register slave.
`timescale 1ns/1ps
`default_nettype none
module ldr_top_bench
  import ldr_pkg::*;
;
  logic        clk;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  lutAAddress;
  logic [3:0]  lutBAddress;
  logic        directInputLine;
  logic        auxInputLine;
  logic        setResetLine;
  logic        lutAOut;
  logic        lutBOut;
  logic        lutAReg;
  logic        lutBReg;
  logic        lutHReg;
  int          err_count;
  int          compares;

  ldr_top u_ldr_top (.clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .lutAAddress, .lutBAddress, .directInputLine, .auxInputLine, .setResetLine,
    .lutAOut, .lutBOut, .lutAReg, .lutBReg, .lutHReg);
  ldr_user_logic u_ldr_user_logic (.clk, .lutAAddress, .lutBAddress, .directInputLine, .auxInputLine,
    .setResetLine);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is seen high at a rising edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 8; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 8) begin
      err_count++;
      wrap_up();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    xfer(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic expErr);
    logic [31:0] got;
    logic        err;
    xfer(1'b0, a, 32'h0000_0000, got, err);
    chk(got, exp);
    chk({31'h0, err}, {31'h0, expErr});
  endtask : rd

  // Drives the RAM port for one cycle and checks both combinational reads within that cycle.
  task automatic look(input logic [3:0] a, input logic [3:0] b, input logic d, input logic x, input logic we,
                      input logic expA, input logic expB);
    u_ldr_user_logic.drive(a, b, d, x, we);
    @(negedge clk);
    chk({30'h0, lutAOut, lutBOut}, {30'h0, expA, expB});
  endtask : look

  task automatic clear(input logic [31:0] ctrl);
    wr(LDR_OFF_CTRL, ctrl);
    wr(LDR_OFF_FUNC_A, 32'h0000_0000);
    wr(LDR_OFF_FUNC_B, 32'h0000_0000);
  endtask : clear

  initial begin
    err_count = 0;
    compares  = 0;
    rst_b     = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h00;
    pwdata    = 32'h0000_0000;
    // The cells carry no reset, so both tables are cleared through the user port while reset is held.
    for (int k = 0; k < 16; k++) begin
      u_ldr_user_logic.drive(4'(k), 4'(k), 1'b0, 1'b0, 1'b1);
    end
    rst_b <= 1'b1;
    u_ldr_user_logic.drive(4'h0, 4'h0, 1'b0, 1'b0, 1'b0);
    repeat (3) @(posedge clk);
    rd(LDR_OFF_CTRL, 32'h0000_0018, 1'b0);
    rd(8'h10, 32'h0000_0000, 1'b1);
    wr(LDR_OFF_CTRL, 32'hFFFF_FFFF);
    rd(LDR_OFF_CTRL, 32'h0000_FF1F, 1'b0);
    // Pair mode, edge-triggered: a write shows only after its edge.
    clear(32'h0000_0018);
    look(4'h5, 4'h9, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    look(4'h5, 4'h9, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    look(4'h5, 4'h9, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    chk({30'h0, lutAReg, lutBReg}, 32'h0000_0003);
    rd(LDR_OFF_FUNC_A, 32'h0000_0020, 1'b0);
    rd(LDR_OFF_FUNC_B, 32'h0000_0200, 1'b0);
    rd(LDR_OFF_STATUS, 32'h0000_000F, 1'b0);
    look(4'h3, 4'h3, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    look(4'h3, 4'h3, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    // Only A is memory; B stays a logic table and ignores the strobe.
    wr(LDR_OFF_CTRL, 32'h0000_0008);
    wr(LDR_OFF_FUNC_B, 32'h0000_8000);
    look(4'h0, 4'hF, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    look(4'h0, 4'hE, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    rd(LDR_OFF_FUNC_B, 32'h0000_8000, 1'b0);
    // Only B is memory; A keeps its loaded table although the strobe is high.
    wr(LDR_OFF_CTRL, 32'h0000_0010);
    wr(LDR_OFF_FUNC_A, 32'h0000_0001);
    look(4'h0, 4'h1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    look(4'h0, 4'h1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    rd(LDR_OFF_FUNC_A, 32'h0000_0001, 1'b0);
    // Wide mode: the high data line picks the generator.
    clear(32'h0000_0019);
    look(4'h3, 4'h0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    look(4'h3, 4'h0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    look(4'h3, 4'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    rd(LDR_OFF_FUNC_A, 32'h0000_0000, 1'b0);
    rd(LDR_OFF_FUNC_B, 32'h0000_0008, 1'b0);
    // Dual port: write and second read at one address in one cycle.
    clear(32'h0000_001A);
    look(4'h7, 4'h7, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    look(4'h7, 4'h7, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    look(4'h7, 4'h2, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    rd(LDR_OFF_FUNC_A, 32'h0000_0080, 1'b0);
    rd(LDR_OFF_FUNC_B, 32'h0000_0080, 1'b0);
    // Dual port ignores level-sensitive timing: the write shows only after its edge.
    clear(32'h0000_001E);
    look(4'h7, 4'h7, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    look(4'h7, 4'h7, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
    // Level-sensitive: both generators pass the strobed data at once.
    clear(32'h0000_801C);
    look(4'h4, 4'h6, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1);
    look(4'h4, 4'h6, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    look(4'h4, 4'h6, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
    chk({31'h0, lutHReg}, 32'h0000_0001);
    rd(LDR_OFF_FUNC_A, 32'h0000_0010, 1'b0);
    wrap_up();
  end
endmodule : ldr_top_bench
`default_nettype wire
